// >>> core/ppci_pin_ports.sv
// pin logic for the latch-only first port and the bidirectional second port
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ppci_pin_ports (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  // register port
  input  wire logic [ppci_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [ppci_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output var  logic [ppci_pkg::DATA_W-1:0]    reg_rdata,
  // first port pins
  input  wire logic [ppci_pkg::FIRST_W-1:0]   first_port_pins_in,
  output var  logic [ppci_pkg::FIRST_W-1:0]   first_port_pins_out,
  output var  logic [ppci_pkg::FIRST_W-1:0]   first_port_pins_oe,
  // second port pins
  input  wire logic [ppci_pkg::SECOND_W-1:0]  second_port_pins_in,
  output var  logic [ppci_pkg::SECOND_W-1:0]  second_port_pins_out,
  output var  logic [ppci_pkg::SECOND_W-1:0]  second_port_pins_oe,
  output var  logic [ppci_pkg::SECOND_W-1:0]  second_port_pullup_on,
  // peripherals
  input  wire logic [1:0]                     serial_oe,
  input  wire logic [1:0]                     serial_out,
  output var  logic [1:0]                     serial_in,
  output var  logic                           timer_zero_clk_in,
  input  wire logic [ppci_pkg::SECOND_W-1:0]  periph_oe,
  input  wire logic [ppci_pkg::SECOND_W-1:0]  periph_out,
  output var  logic [ppci_pkg::SECOND_W-1:0]  periph_in,
  // interrupt and wake
  output var  logic                           irq,
  output var  logic                           wake_req
);
  import ppci_pkg::*;

  // synchronisers: stage one is read only by stage two
  logic [FIRST_W-1:0]  first_meta_reg;
  logic [FIRST_W-1:0]  first_sync_reg;
  logic [SECOND_W-1:0] second_meta_reg;
  logic [SECOND_W-1:0] second_sync_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_meta_reg  <= '0;
      first_sync_reg  <= '0;
      second_meta_reg <= '0;
      second_sync_reg <= '0;
    end else begin
      first_meta_reg  <= first_port_pins_in;
      first_sync_reg  <= first_meta_reg;
      second_meta_reg <= second_port_pins_in;
      second_sync_reg <= second_meta_reg;
    end
  end

  // software state
  logic [FIRST_W-1:0]  first_port_latch_reg;
  logic [FIRST_W-1:0]  first_port_latch_next;
  logic                pullup_enable_n_reg;
  logic                pullup_enable_n_next;
  logic [SECOND_W-1:0] second_port_latch_reg;
  logic [SECOND_W-1:0] second_port_latch_next;
  logic [SECOND_W-1:0] second_port_direction_reg;
  logic [SECOND_W-1:0] second_port_direction_next;
  logic                port_change_flag_reg;
  logic                port_change_flag_next;
  logic                change_mask_reg;
  logic                change_mask_next;
  logic [DATA_W-1:0]   rdata_next;
  logic [SECOND_W-1:0] mismatch;
  logic                any_mismatch;
  logic                flag_clear;

  always_comb begin
    first_port_latch_next      = first_port_latch_reg;
    pullup_enable_n_next       = pullup_enable_n_reg;
    second_port_latch_next     = second_port_latch_reg;
    second_port_direction_next = second_port_direction_reg;
    change_mask_next           = change_mask_reg;
    flag_clear                 = 1'b0;
    rdata_next                 = '0;
    // only pins set as input in the direction register take part in the comparison, even when the peripheral drives them
    mismatch     = second_port_direction_reg & (second_sync_reg ^ second_port_latch_reg);
    any_mismatch = |mismatch;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_FIRST: begin
          first_port_latch_next = reg_wdata[FIRST_W-1:0];
          pullup_enable_n_next  = reg_wdata[PULLUP_N_BIT];
        end
        ADDR_SECOND:    second_port_latch_next = reg_wdata;
        ADDR_DIRECTION: second_port_direction_next = reg_wdata;
        ADDR_IRQ_FLAGS: flag_clear = ~reg_wdata[CHANGE_FLAG_BIT];
        ADDR_IRQ_MASK:  change_mask_next = reg_wdata[CHANGE_FLAG_BIT];
        default: ;
      endcase
    end
    // set wins over clear while a mismatch persists
    port_change_flag_next = (port_change_flag_reg & ~flag_clear) | any_mismatch;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_FIRST:     rdata_next = {pullup_enable_n_reg, 1'b0, first_sync_reg};
        ADDR_SECOND:    rdata_next = second_sync_reg;
        ADDR_DIRECTION: rdata_next = second_port_direction_reg;
        ADDR_IRQ_FLAGS: rdata_next = {port_change_flag_reg, 7'h00};
        ADDR_IRQ_MASK:  rdata_next = {change_mask_reg, 7'h00};
        default:        rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_port_latch_reg      <= FIRST_RST;
      pullup_enable_n_reg       <= PULLUP_N_RST;
      second_port_latch_reg     <= SECOND_RST;
      second_port_direction_reg <= DIRECTION_RST;
      port_change_flag_reg      <= 1'b0;
      change_mask_reg           <= MASK_RST;
      reg_rdata                 <= '0;
    end else begin
      first_port_latch_reg      <= first_port_latch_next;
      pullup_enable_n_reg       <= pullup_enable_n_next;
      second_port_latch_reg     <= second_port_latch_next;
      second_port_direction_reg <= second_port_direction_next;
      port_change_flag_reg      <= port_change_flag_next;
      change_mask_reg           <= change_mask_next;
      reg_rdata                 <= rdata_next;
    end
  end

  // pin drive, computed from next state so outputs are registered
  logic [FIRST_W-1:0]  first_out_next;
  logic [FIRST_W-1:0]  first_oe_next;
  logic [SECOND_W-1:0] second_out_next;
  logic [SECOND_W-1:0] second_oe_next;
  logic [SECOND_W-1:0] pullup_next;

  always_comb begin
    first_out_next = '0;
    first_oe_next  = '0;
    for (int i = OD_PIN_LO; i <= OD_PIN_HI; i++) begin
      first_oe_next[i] = ~first_port_latch_next[i];
    end
    first_out_next[SERIAL_PIN_LO +: 2] = serial_out;
    first_oe_next[SERIAL_PIN_LO +: 2]  = serial_oe;
  end

  // per-pin drive of the second port
  for (genvar g = 0; g < SECOND_W; g++) begin : g_second
    always_comb begin
      second_oe_next[g]  = periph_oe[g] | ~second_port_direction_next[g];
      second_out_next[g] = periph_oe[g] ? periph_out[g] : second_port_latch_next[g];
      pullup_next[g]     = ~pullup_enable_n_next & ~second_oe_next[g];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_port_pins_out   <= '0;
      first_port_pins_oe    <= '0;
      second_port_pins_out  <= '0;
      second_port_pins_oe   <= '0;
      second_port_pullup_on <= '1;
      serial_in             <= '0;
      timer_zero_clk_in     <= 1'b0;
      periph_in             <= '0;
      irq                   <= 1'b0;
      wake_req              <= 1'b0;
    end else begin
      first_port_pins_out   <= first_out_next;
      first_port_pins_oe    <= first_oe_next;
      second_port_pins_out  <= second_out_next;
      second_port_pins_oe   <= second_oe_next;
      second_port_pullup_on <= pullup_next;
      serial_in             <= first_sync_reg[SERIAL_PIN_LO +: 2];
      timer_zero_clk_in     <= first_sync_reg[TIMER_PIN];
      periph_in             <= second_sync_reg;
      irq                   <= port_change_flag_next & change_mask_next;
      wake_req              <= port_change_flag_next;
    end
  end

  // checks
  property p_od_drive;
    @(posedge ref_clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_FIRST |=> first_port_pins_oe[OD_PIN_HI:OD_PIN_LO]
        == ~$past(reg_wdata[OD_PIN_HI:OD_PIN_LO]) && first_port_pins_out[3:2] == 2'b00;
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open-drain drive wrong");

  property p_serial_pins;
    @(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> first_port_pins_oe[5:4] == $past(serial_oe)
        && first_port_pins_out[5:4] == $past(serial_out);
  endproperty
  a_serial_pins: assert property (p_serial_pins) else $error("serial pins not followed");

  property p_pullup_off_output;
    @(posedge ref_clk) disable iff (sys_rst)
      (second_port_pullup_on & second_port_pins_oe) == '0;
  endproperty
  a_pullup_off_output: assert property (p_pullup_off_output) else $error("pull-up on output");

  property p_pullup_ctl;
    @(posedge ref_clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_FIRST && reg_wdata[PULLUP_N_BIT]
        |=> second_port_pullup_on == '0;
  endproperty
  a_pullup_ctl: assert property (p_pullup_ctl) else $error("pull-ups not disabled");

  property p_reset_pullup;
    @(posedge ref_clk) $past(sys_rst) |-> second_port_pullup_on == '1;
  endproperty
  a_reset_pullup: assert property (p_reset_pullup) else $error("pull-ups off after reset");

  property p_flag_set;
    @(posedge ref_clk) disable iff (sys_rst)
      any_mismatch |=> port_change_flag_reg ##0 wake_req;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("mismatch did not set flag");

  property p_flag_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_IRQ_FLAGS && !reg_wdata[CHANGE_FLAG_BIT] && !any_mismatch
        |=> !port_change_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_output_excluded;
    @(posedge ref_clk) disable iff (sys_rst)
      second_port_direction_reg == '0 |-> !any_mismatch;
  endproperty
  a_output_excluded: assert property (p_output_excluded) else $error("output pin compared");

  property p_read_second;
    @(posedge ref_clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_SECOND |=> reg_rdata == $past(second_sync_reg);
  endproperty
  a_read_second: assert property (p_read_second) else $error("second port read wrong");

  property p_sync_delay;
    @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && !$past(sys_rst, 2)
        |-> second_sync_reg == $past(second_port_pins_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong");

  property p_irq_level;
    @(posedge ref_clk) disable iff (sys_rst)
      irq |-> port_change_flag_reg && change_mask_reg;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq without cause");

  c_change_irq: cover property (@(posedge ref_clk) disable iff (sys_rst)
    any_mismatch ##1 irq);
  c_clear_after_rewrite: cover property (@(posedge ref_clk) disable iff (sys_rst)
    port_change_flag_reg && reg_wr && reg_addr == ADDR_SECOND ##[1:20]
    !port_change_flag_reg);
  c_od_low: cover property (@(posedge ref_clk) disable iff (sys_rst)
    first_port_pins_oe[OD_PIN_LO]);
  c_periph_take: cover property (@(posedge ref_clk) disable iff (sys_rst)
    |periph_oe);

endmodule : ppci_pin_ports
`default_nettype wire

// >>> core/ppci_pkg.sv
// constants, register map and field layout of the pin ports block
package ppci_pkg;
  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 8;
  localparam int          FIRST_W         = 6;
  localparam int          SECOND_W        = 8;
  localparam int          SYNC_STAGES     = 2;
  localparam logic [2:0]  ADDR_FIRST      = 3'h0;
  localparam logic [2:0]  ADDR_SECOND     = 3'h1;
  localparam logic [2:0]  ADDR_DIRECTION  = 3'h2;
  localparam logic [2:0]  ADDR_IRQ_FLAGS  = 3'h3;
  localparam logic [2:0]  ADDR_IRQ_MASK   = 3'h4;
  localparam int          PULLUP_N_BIT    = 7;
  localparam int          CHANGE_FLAG_BIT = 7;
  localparam int          TIMER_PIN       = 1;
  localparam int          OD_PIN_LO       = 2;
  localparam int          OD_PIN_HI       = 3;
  localparam int          SERIAL_PIN_LO   = 4;
  localparam logic [5:0]  FIRST_RST       = 6'h3f;
  localparam logic        PULLUP_N_RST    = 1'b0;
  localparam logic [7:0]  SECOND_RST      = 8'h00;
  localparam logic [7:0]  DIRECTION_RST   = 8'hff;
  localparam logic        MASK_RST        = 1'b0;
endpackage : ppci_pkg

// >>> tb/ppci_pin_model.sv
// external circuit model for the first and second port pins
`timescale 1ns/10ps
`default_nettype none
module ppci_pin_model (
  // clock
  input  wire logic       ref_clk,
  // design drive
  input  wire logic [5:0] first_out,
  input  wire logic [5:0] first_oe,
  input  wire logic [7:0] second_out,
  input  wire logic [7:0] second_oe,
  input  wire logic [7:0] pullup_on,
  // outside drivers
  input  wire logic [5:0] ext_first,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // resolved levels
  output var  logic [5:0] first_pins,
  output var  logic [7:0] second_pins
);
  logic [7:0] float_reg = 8'h55;
  // an undriven line without pull-up wanders each cycle
  always_ff @(posedge ref_clk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    first_pins  = (first_oe & first_out) | (~first_oe & (6'h0c | ext_first));
    second_pins = (second_oe & second_out) | (~second_oe & ext_en & ext_val)
                | (~second_oe & ~ext_en & (pullup_on | float_reg));
  end
endmodule : ppci_pin_model
`default_nettype wire

// >>> tb/ppci_pin_ports_bench.sv
// self-checking bench for the pin ports block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module ppci_pin_ports_bench;
  import ppci_pkg::*;
  logic       ref_clk, sys_rst, reg_wr, reg_rd, tmr_in, irq, wake_req;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got, s_pins, s_out, s_oe, pu_on;
  logic [7:0] periph_oe, periph_out, periph_in, ext_en, ext_val;
  logic [5:0] f_pins, f_out, f_oe, ext_first;
  logic [1:0] serial_oe, serial_out, serial_in;
  logic [39:0] rows [4];
  int         fail_count, compares;
  ppci_pin_ports i_ppci_pin_ports (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_port_pins_in(f_pins), .first_port_pins_out(f_out), .first_port_pins_oe(f_oe),
    .second_port_pins_in(s_pins), .second_port_pins_out(s_out), .second_port_pins_oe(s_oe),
    .second_port_pullup_on(pu_on), .serial_oe(serial_oe), .serial_out(serial_out),
    .serial_in(serial_in), .timer_zero_clk_in(tmr_in), .periph_oe(periph_oe),
    .periph_out(periph_out), .periph_in(periph_in), .irq(irq), .wake_req(wake_req));
  ppci_pin_model i_ppci_pin_model (.ref_clk(ref_clk), .first_out(f_out), .first_oe(f_oe),
    .second_out(s_out), .second_oe(s_oe), .pullup_on(pu_on), .ext_first(ext_first),
    .ext_en(ext_en), .ext_val(ext_val), .first_pins(f_pins), .second_pins(s_pins));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd
  task automatic settle;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wait_wake;
    int n;
    n = 0;
    while (wake_req !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (wake_req !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED wake_req expected 1 seen %b", wake_req);
      give_verdict();
    end
  endtask : wait_wake
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    // direction, latch, drive enable, drive value, expected read
    rows = '{40'hff00ffa5a5, 40'h003cffc33c, 40'hf00a0000fa, 40'h0f500f0656};
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 3'h0, 8'h00};
    {periph_oe, periph_out, serial_oe, serial_out} = '0;
    {ext_first, ext_en, ext_val} = {6'h23, 8'hff, 8'h00};
    {fail_count, compares} = '0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DIRECTION, rows[i][39:32]);
      wr(ADDR_SECOND, rows[i][31:24]);
      ext_en  <= rows[i][23:16];
      ext_val <= rows[i][15:8];
      settle();
      `CHK("second oe", ~rows[i][39:32], s_oe)
      `CHK("pullup_on", rows[i][39:32], pu_on)
      rd(ADDR_SECOND);
      `CHK("second read", rows[i][7:0], got)
    end
    $display("test table done");
    @(posedge ref_clk);
    ext_en  <= 8'hff;
    ext_val <= 8'h00;
    wr(ADDR_DIRECTION, 8'hff);
    wr(ADDR_SECOND, 8'h00);
    settle();
    wr(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h80);
    ext_val <= 8'h01;
    wait_wake();
    `CHK("irq", 1'b1, irq)
    wr(ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_IRQ_FLAGS);
    `CHK("flags kept", 8'h80, got)
    rd(ADDR_SECOND);
    `CHK("synced read", 8'h01, got)
    wr(ADDR_SECOND, got);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    settle();
    `CHK("irq cleared", 1'b0, irq)
    rd(ADDR_IRQ_FLAGS);
    `CHK("flags cleared", 8'h00, got)
    wr(ADDR_DIRECTION, 8'hfe);
    periph_oe <= 8'h01;
    settle();
    `CHK("output excluded", 1'b0, wake_req)
    `CHK("periph_in", 1'b0, periph_in[0])
    $display("test change done");
    wr(ADDR_FIRST, 8'h33);
    settle();
    `CHK("first oe", 6'h0c, f_oe)
    `CHK("first out", 2'b00, f_out[3:2])
    wr(ADDR_FIRST, 8'hbf);
    settle();
    `CHK("first released", 6'h00, f_oe)
    `CHK("pullups off", 8'h00, pu_on)
    rd(ADDR_FIRST);
    `CHK("first read", 8'haf, got)
    `CHK("timer in", 1'b1, tmr_in)
    @(posedge ref_clk);
    serial_oe  <= 2'b11;
    serial_out <= 2'b01;
    settle();
    `CHK("serial oe", 6'h30, f_oe)
    `CHK("serial out", 2'b01, f_out[5:4])
    `CHK("serial in", 2'b01, serial_in)
    rd(ADDR_FIRST);
    `CHK("first serial read", 8'h9f, got)
    rd(3'h5);
    `CHK("unmapped", 8'h00, got)
    $display("test first port done");
    @(posedge ref_clk);
    serial_oe <= 2'b00;
    periph_oe <= 8'h00;
    sys_rst   <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle();
    `CHK("pullups after reset", 8'hff, pu_on)
    rd(ADDR_DIRECTION);
    `CHK("direction reset", 8'hff, got)
    rd(ADDR_FIRST);
    `CHK("first reset read", 8'h2f, got)
    rd(ADDR_IRQ_MASK);
    `CHK("mask reset", 8'h00, got)
    $display("test reset done");
    give_verdict();
  end
endmodule : ppci_pin_ports_bench
`default_nettype wire
